// ### shared/loop_dac_regs.svh
// register layout, command codes and timing constants of the loop converter control block
`ifndef LOOP_DAC_REGS_SVH
`define LOOP_DAC_REGS_SVH

// operating_config layout
`define CTRL_RESET      16'h6000
`define CTRL_MASK       16'hFFE0
`define CTRL_TMO_B0     15
`define CTRL_TMO_B1     14
`define CTRL_TMO_B2     13
`define CTRL_WD_DIS     12
`define CTRL_AUTO_DIS   11
`define CTRL_ALARM_DIS  10
`define CTRL_MIN_CUR    9
`define CTRL_ADC_TEMP   8
`define CTRL_ADC_EN     7
`define CTRL_REF_PD     6
`define CTRL_LOOP_ALERT 5

// fault register bits carried by this block
`define FAULT_SERIAL    15
`define FAULT_LOOP_LOW  9

// address/command byte codes
`define CMD_WR_DAC      8'h01
`define CMD_WR_CTRL     8'h02
`define CMD_WR_OFFS     8'h03
`define CMD_WR_GAIN     8'h04
`define CMD_NOP         8'h09
`define CMD_RD_CTRL     8'h82
`define CMD_RD_FAULT    8'h85

// frame shape
`define FRAME_BITS      6'd24
`define CMD_MSB         23
`define CMD_LSB         16
`define DATA_MSB        15
`define BITCNT_MAX      6'h3F

// timing
`define CLK_PERIOD_PS   8000
`define PS_PER_MS       1000000000
`define WD_MS_CYCLES    (`PS_PER_MS / `CLK_PERIOD_PS)
`define TMO_50MS        13'd50
`define TMO_100MS       13'd100
`define TMO_500MS       13'd500
`define TMO_1S          13'd1000
`define TMO_2S          13'd2000
`define TMO_3S          13'd3000
`define TMO_4S          13'd4000
`define TMO_5S          13'd5000

`endif

// ### shared/loop_dac_pkg.sv
// types shared by the loop converter control block
package loop_dac_pkg;

	typedef enum logic [1:0] {
		LINK_IDLE  = 2'b01,
		LINK_SHIFT = 2'b10
	} link_state_t;

	typedef struct packed {
		link_state_t st;
		logic        sclkPrev;
		logic        syncPrev;
		logic [23:0] shiftIn;
		logic [5:0]  bitCnt;
		logic [23:0] shiftOut;
		logic        sdo;
		logic        faultShown;
		logic [15:0] cfg;
		logic [7:0]  readCmd;
		logic        serialFault;
		logic        loopLow;
	} ctrl_state_t;

	typedef struct packed {
		logic [31:0] pre;
		logic [12:0] ms;
	} wd_state_t;

endpackage

// ### hw/serial_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module serial_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb begin
		s_d.meta = asyncIn;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= {RST_VAL, RST_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign syncOut = s_q.stable;
endmodule

// ### hw/serial_watchdog.sv
// serial watchdog: millisecond prescaler and programmable timeout
`timescale 1ns/1ps
`include "loop_dac_regs.svh"
module serial_watchdog #(
	parameter int unsigned MS_CYCLES = `WD_MS_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       enable,
	input  wire logic       restart,
	input  wire logic [2:0] timeoutSel,
	output logic            expire
);
	import loop_dac_pkg::*;

	wd_state_t s_q;
	wd_state_t s_d;
	logic      msTick;

	function automatic logic [12:0] timeoutMs(input logic [2:0] code);
		unique case (code)
			3'h0: timeoutMs = `TMO_50MS;
			3'h1: timeoutMs = `TMO_100MS;
			3'h2: timeoutMs = `TMO_500MS;
			3'h3: timeoutMs = `TMO_1S;
			3'h4: timeoutMs = `TMO_2S;
			3'h5: timeoutMs = `TMO_3S;
			3'h6: timeoutMs = `TMO_4S;
			default: timeoutMs = `TMO_5S;
		endcase
	endfunction

	assign msTick = (s_q.pre == 32'(MS_CYCLES - 1));
	assign expire = enable && msTick && (s_q.ms == timeoutMs(timeoutSel) - 13'd1);

	always_comb begin
		s_d = s_q;
		// restart or stop clears the count
		if (!enable || restart || expire) begin
			s_d = '0;
		end else if (msTick) begin
			s_d.pre = '0;
			s_d.ms = s_q.ms + 13'd1;
		end else begin
			s_d.pre = s_q.pre + 32'd1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ### hw/loop_dac_control_register.sv
// operating control register, serial frame engine and serial watchdog of the loop converter
// Summary of operation
// - the three timeout bits select 50 ms up to 5 s, code 011 (1 s) after reset.
// - a completed valid register write or a no-operation restarts the watchdog; the host must access in time.
// - with auto readback at 0 the fault word is shifted out on every frame, at 1 nothing automatic.
// - a watchdog expiry is a serial fault.
// - with the alarm bit at 0 a serial fault forces the alarm current, at 1 it does not.
// - a serial fault always sets its fault flag and the fault alert pin.
// - the minimum current bit at 1 drives the output current to its minimum.
// - the monitor select bit picks loop supply sense at 0 and die temperature at 1.
// - the reference power-down bit at 1 powers the internal reference down.
// - with the loop alert bit at 1 a low loop supply sense asserts the fault alert pin.
// - the low loop flag is set on a low loop supply sense whatever the alert bit holds.
`timescale 1ns/1ps
`include "loop_dac_regs.svh"
module loop_dac_control_register #(
	parameter int unsigned MS_CYCLES = `WD_MS_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic sclk,
	input  wire logic sync_n,
	input  wire logic sdin,
	output logic      sdo,
	input  wire logic loopLowIn,
	output logic      faultAlert,
	output logic      alarmCurrent,
	output logic      minCurrent,
	output logic      adcSelTemp,
	output logic      adcEnable,
	output logic      refPowerDown
);
	import loop_dac_pkg::*;

	ctrl_state_t s_q;
	ctrl_state_t s_d;
	logic [3:0]  pinSync;
	logic        sclkS;
	logic        syncS;
	logic        sdinS;
	logic        loopLowS;
	logic        sclkFall;
	logic        sclkRise;
	logic        syncFall;
	logic        syncRise;
	logic        frameDone;
	logic        wdRestart;
	logic        wdExpire;
	logic [7:0]  cmdByte;
	logic [15:0] dataWord;
	logic [15:0] faultWord;
	logic [15:0] outWord;
	logic [23:0] outFrame;

	// pins cross into ref_clk before any decode; idle-high pins reset high so
	// that the release of reset shows no false edge
	serial_sync #(
		.WIDTH  (4),
		.RST_VAL(4'hC)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_n  (rst_n),
		.asyncIn({sclk, sync_n, sdin, loopLowIn}),
		.syncOut(pinSync)
	);

	assign sclkS = pinSync[3];
	assign syncS = pinSync[2];
	assign sdinS = pinSync[1];
	assign loopLowS = pinSync[0];

	serial_watchdog #(
		.MS_CYCLES(MS_CYCLES)
	) u_wdog (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.enable    (!s_q.cfg[`CTRL_WD_DIS]),
		.restart   (wdRestart),
		.timeoutSel({s_q.cfg[`CTRL_TMO_B0], s_q.cfg[`CTRL_TMO_B1], s_q.cfg[`CTRL_TMO_B2]}),
		.expire    (wdExpire)
	);

	assign sclkFall = s_q.sclkPrev && !sclkS;
	assign sclkRise = !s_q.sclkPrev && sclkS;
	assign syncFall = s_q.syncPrev && !syncS;
	assign syncRise = !s_q.syncPrev && syncS;
	assign cmdByte = s_q.shiftIn[`CMD_MSB:`CMD_LSB];
	assign dataWord = s_q.shiftIn[`DATA_MSB:0];
	// frames of any other length (crc frames too) are dropped whole
	assign frameDone = (s_q.st == LINK_SHIFT) && syncRise && (s_q.bitCnt == `FRAME_BITS);

	// restart on valid register writes and no-operation
	assign wdRestart = frameDone && (cmdByte == `CMD_WR_DAC || cmdByte == `CMD_WR_CTRL ||
		cmdByte == `CMD_WR_OFFS || cmdByte == `CMD_WR_GAIN || cmdByte == `CMD_NOP);

	always_comb begin
		faultWord = '0;
		faultWord[`FAULT_SERIAL] = s_q.serialFault;
		faultWord[`FAULT_LOOP_LOW] = s_q.loopLow;
	end

	// fault word goes out unless auto readback is off
	always_comb begin
		if (!s_q.cfg[`CTRL_AUTO_DIS]) begin
			outWord = faultWord;
		end else if (s_q.readCmd == `CMD_RD_CTRL) begin
			outWord = s_q.cfg;
		end else if (s_q.readCmd == `CMD_RD_FAULT) begin
			outWord = faultWord;
		end else begin
			outWord = '0;
		end
	end

	assign outFrame = {8'h00, outWord};

	always_comb begin
		s_d = s_q;
		s_d.sclkPrev = sclkS;
		s_d.syncPrev = syncS;
		// low loop flag ignores the alert bit
		s_d.loopLow = loopLowS;
		unique case (s_q.st)
			LINK_IDLE: begin
				if (syncFall) begin
					s_d.st = LINK_SHIFT;
					s_d.bitCnt = '0;
					s_d.sdo = outFrame[23];
					s_d.shiftOut = {outFrame[22:0], 1'b0};
					s_d.faultShown = !s_q.cfg[`CTRL_AUTO_DIS] ||
						(s_q.readCmd == `CMD_RD_FAULT);
				end
			end
			LINK_SHIFT: begin
				if (syncRise) begin
					s_d.st = LINK_IDLE;
					s_d.sdo = 1'b0;
				end else begin
					if (sclkFall) begin
						s_d.shiftIn = {s_q.shiftIn[22:0], sdinS};
						if (s_q.bitCnt != `BITCNT_MAX) begin
							s_d.bitCnt = s_q.bitCnt + 6'd1;
						end
					end
					if (sclkRise) begin
						s_d.sdo = s_q.shiftOut[23];
						s_d.shiftOut = {s_q.shiftOut[22:0], 1'b0};
					end
				end
			end
		endcase
		if (frameDone) begin
			s_d.readCmd = cmdByte;
			if (cmdByte == `CMD_WR_CTRL) begin
				s_d.cfg = dataWord & `CTRL_MASK;
			end
			// serial fault clears once the host has been shown it
			if (s_q.faultShown) begin
				s_d.serialFault = 1'b0;
			end
		end
		// expiry raises the serial fault, set beats clear
		if (wdExpire) begin
			s_d.serialFault = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.st <= LINK_IDLE;
			s_q.sclkPrev <= 1'b1;
			s_q.syncPrev <= 1'b1;
			s_q.cfg <= `CTRL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign sdo = s_q.sdo;
	// alert from serial fault or routed low loop
	assign faultAlert = s_q.serialFault || (s_q.cfg[`CTRL_LOOP_ALERT] && s_q.loopLow);
	// alarm unless suppressed by the alarm bit
	assign alarmCurrent = s_q.serialFault && !s_q.cfg[`CTRL_ALARM_DIS];
	assign minCurrent = s_q.cfg[`CTRL_MIN_CUR];
	assign adcSelTemp = s_q.cfg[`CTRL_ADC_TEMP];
	assign adcEnable = s_q.cfg[`CTRL_ADC_EN];
	assign refPowerDown = s_q.cfg[`CTRL_REF_PD];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence ctrlWriteSeq;
		frameDone && (cmdByte == `CMD_WR_CTRL);
	endsequence

	sequence autoFrameStartSeq;
		(s_q.st == LINK_IDLE) && syncFall && !s_q.cfg[`CTRL_AUTO_DIS];
	endsequence

	a_ctrl_write_mask: assert property (ctrlWriteSeq |=>
		s_q.cfg == ($past(dataWord) & `CTRL_MASK))
		else $error("control write did not store masked data");

	a_reserved_zero: assert property ((s_q.cfg & ~`CTRL_MASK) == 16'h0000)
		else $error("reserved control bits not zero");

	a_expire_sets_fault: assert property (wdExpire |=> s_q.serialFault)
		else $error("watchdog expiry did not set serial fault");

	a_wd_stopped: assert property (s_q.cfg[`CTRL_WD_DIS] |-> !wdExpire)
		else $error("watchdog expired while disabled");

	a_restart_nop: assert property (frameDone && cmdByte == `CMD_NOP |-> wdRestart)
		else $error("no-operation did not restart watchdog");

	a_alarm_force: assert property (wdExpire && !s_q.cfg[`CTRL_ALARM_DIS] &&
		!(frameDone && cmdByte == `CMD_WR_CTRL && dataWord[`CTRL_ALARM_DIS]) |=> alarmCurrent)
		else $error("serial fault did not force alarm current");

	a_alarm_blocked: assert property (s_q.cfg[`CTRL_ALARM_DIS] |-> !alarmCurrent)
		else $error("alarm forced while suppressed");

	a_fault_pin: assert property (wdExpire |=> faultAlert)
		else $error("serial fault did not raise fault alert");

	a_loop_alert: assert property (!s_q.serialFault && !s_q.cfg[`CTRL_LOOP_ALERT]
		|-> !faultAlert)
		else $error("fault alert raised by unrouted loop condition");

	a_loop_flag: assert property ($rose(loopLowS) |=> faultWord[`FAULT_LOOP_LOW])
		else $error("low loop flag not set");

	a_auto_readback: assert property (autoFrameStartSeq |=>
		s_q.sdo == 1'b0 && s_q.shiftOut == {7'h00, $past(faultWord), 1'b0})
		else $error("fault word not loaded for automatic readback");

	a_tmo_default: assert property ($rose(rst_n) |->
		{s_q.cfg[`CTRL_TMO_B0], s_q.cfg[`CTRL_TMO_B1], s_q.cfg[`CTRL_TMO_B2]} == 3'h3)
		else $error("timeout code not 1 s after reset");

	sequence cutFrameSeq;
		(s_q.st == LINK_SHIFT) && syncRise && (s_q.bitCnt != `FRAME_BITS);
	endsequence

	sequence readCtrlStartSeq;
		(s_q.st == LINK_IDLE) && syncFall && s_q.cfg[`CTRL_AUTO_DIS] &&
		(s_q.readCmd == `CMD_RD_CTRL);
	endsequence

	a_min_current: assert property (ctrlWriteSeq |=>
		minCurrent == $past(dataWord[`CTRL_MIN_CUR]))
		else $error("minimum current bit not applied");

	a_adc_select: assert property (ctrlWriteSeq |=>
		adcSelTemp == $past(dataWord[`CTRL_ADC_TEMP]))
		else $error("monitor select bit not applied");

	a_adc_enable: assert property (ctrlWriteSeq |=>
		adcEnable == $past(dataWord[`CTRL_ADC_EN]))
		else $error("monitor enable bit not applied");

	a_ref_down: assert property (ctrlWriteSeq |=>
		refPowerDown == $past(dataWord[`CTRL_REF_PD]))
		else $error("reference power down bit not applied");

	// a cut frame must neither write, restart nor change the readback choice
	a_cut_frame: assert property (cutFrameSeq |-> !wdRestart ##1
		($stable(s_q.cfg) && $stable(s_q.readCmd)))
		else $error("cut frame was acted on");

	a_cfg_hold: assert property (!(frameDone && cmdByte == `CMD_WR_CTRL) |=>
		$stable(s_q.cfg))
		else $error("control register changed without a write");

	a_fault_hold: assert property (s_q.serialFault && !frameDone |=>
		s_q.serialFault)
		else $error("serial fault flag dropped outside a frame end");

	a_fault_no_set: assert property (!s_q.serialFault && !wdExpire |=>
		!s_q.serialFault)
		else $error("serial fault flag set without expiry");

	a_fault_clear: assert property (frameDone && s_q.faultShown && !wdExpire |=>
		!s_q.serialFault)
		else $error("shown serial fault not cleared");

	a_loop_alert_on: assert property (s_q.cfg[`CTRL_LOOP_ALERT] && s_q.loopLow |->
		faultAlert)
		else $error("routed low loop did not raise fault alert");

	a_sdo_idle: assert property ((s_q.st == LINK_IDLE) |-> !sdo)
		else $error("data out not low between frames");

	a_alarm_no_fault: assert property (!s_q.serialFault |-> !alarmCurrent)
		else $error("alarm current without serial fault");

	a_readback_ctrl: assert property (readCtrlStartSeq |=>
		s_q.shiftOut == {7'h00, $past(s_q.cfg), 1'b0})
		else $error("control word not loaded for readback");

	a_shift_bit: assert property ((s_q.st == LINK_SHIFT) && !syncRise && sclkRise |=>
		s_q.sdo == $past(s_q.shiftOut[23]))
		else $error("data out bit not advanced on clock rise");

	a_bit_count: assert property ((s_q.st == LINK_SHIFT) && !syncRise && sclkFall &&
		(s_q.bitCnt != `BITCNT_MAX) |=> s_q.bitCnt == $past(s_q.bitCnt) + 6'd1)
		else $error("frame bit count not advanced on clock fall");
endmodule

// ### testbench/host_model.sv
// host side model driving frames on the serial link of the loop converter control block
`timescale 1ns/1ps
module host_model (
	input  wire logic ref_clk,
	input  wire logic sdo,
	output logic      sclk,
	output logic      sync_n,
	output logic      sdin
);
	// half period of the 64 ns link clock in ref_clk cycles
	localparam int HALF = 4;

	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		sdin = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic frame(input logic [7:0] cmd, input logic [15:0] data, input int nbits,
		output logic [15:0] word);
		logic [23:0] bits;
		bits = {cmd, data};
		word = 16'h0000;
		@(posedge ref_clk);
		sync_n <= 1'b0;
		hold(HALF);
		for (int i = 0; i < nbits; i++) begin
			sdin <= bits[23-i];
			hold(HALF);
			if (i >= 8) word[23-i] = sdo;
			sclk <= 1'b0;
			hold(HALF);
			sclk <= 1'b1;
		end
		hold(HALF);
		sync_n <= 1'b1;
		// a released data line must not keep its last level
		sdin <= ~sdin;
		hold(HALF);
	endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench of the loop converter control block
`timescale 1ns/1ps
`include "loop_dac_regs.svh"
module tb_top;
	// short millisecond so that timeouts fit the run
	localparam int unsigned MS = 10;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        loopLowIn = 1'b0;
	logic        sclk, sync_n, sdin, sdo;
	logic        faultAlert, alarmCurrent, minCurrent;
	logic        adcSelTemp, adcEnable, refPowerDown;
	logic [15:0] word;
	int          errCount = 0;
	int          numChecks = 0;

	always #4 ref_clk = ~ref_clk;

	host_model u_host (
		.ref_clk(ref_clk),
		.sdo(sdo),
		.sclk(sclk),
		.sync_n(sync_n),
		.sdin(sdin)
	);

	loop_dac_control_register #(.MS_CYCLES(MS)) u_dut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sclk(sclk),
		.sync_n(sync_n),
		.sdin(sdin),
		.sdo(sdo),
		.loopLowIn(loopLowIn),
		.faultAlert(faultAlert),
		.alarmCurrent(alarmCurrent),
		.minCurrent(minCurrent),
		.adcSelTemp(adcSelTemp),
		.adcEnable(adcEnable),
		.refPowerDown(refPowerDown)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic finalReport();
		if (errCount == 0 && numChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// waits out a timeout, then clears the fault with a readback frame
	task automatic expiry(input int ms, input logic alarmExp);
		cyc(ms * MS - 20);
		check("alert before timeout", faultAlert, 1'b0);
		cyc(40);
		check("alert after timeout", faultAlert, 1'b1);
		check("alarm current", alarmCurrent, alarmExp);
		u_host.frame(`CMD_NOP, 16'h0000, 24, word);
		check("serial fault flag", word, 16'h8000);
		cyc(2);
		check("alert cleared", faultAlert, 1'b0);
	endtask

	task automatic t_reset();
		cyc(15);
		check("outs in reset", {sdo, faultAlert, alarmCurrent, minCurrent}, 16'h0000);
		check("cfg outs in reset", {adcSelTemp, adcEnable, refPowerDown}, 16'h0000);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(4);
		u_host.frame(`CMD_NOP, 16'h0000, 24, word);
		check("nop fault word", word, 16'h0000);
		expiry(1000, 1'b1);
	endtask

	task automatic t_write();
		u_host.frame(`CMD_WR_CTRL, 16'h2FFF, 24, word);
		cyc(2);
		check("config outs", {minCurrent, adcSelTemp, adcEnable, refPowerDown}, 16'h000F);
		// a frame of the wrong length must be dropped
		u_host.frame(`CMD_WR_CTRL, 16'h2800, 23, word);
		cyc(2);
		check("short frame", minCurrent, 1'b1);
		// auto readback disabled before the read request
		u_host.frame(`CMD_RD_CTRL, 16'h0000, 24, word);
		check("no auto readback", word, 16'h0000);
		u_host.frame(`CMD_NOP, 16'h0000, 24, word);
		check("control readback", word, 16'h2FE0);
	endtask

	task automatic t_timeout();
		int ms[4] = '{50, 100, 500, 1000};
		for (int c = 0; c < 4; c++) begin
			// odd codes also set the alarm disable bit
			u_host.frame(`CMD_WR_CTRL, {c[2:0], 2'b00, c[0], 10'h000}, 24, word);
			expiry(ms[c], ~c[0]);
		end
	endtask

	// every register write restarts the 50 ms watchdog well inside its timeout
	task automatic t_restart();
		u_host.frame(`CMD_WR_CTRL, 16'h0000, 24, word);
		cyc(200);
		u_host.frame(`CMD_WR_DAC, 16'h0000, 24, word);
		cyc(200);
		u_host.frame(`CMD_WR_OFFS, 16'h0000, 24, word);
		cyc(200);
		u_host.frame(`CMD_WR_GAIN, 16'h0000, 24, word);
		check("restart word", word, 16'h0000);
		cyc(200);
		check("restart by writes", faultAlert, 1'b0);
	endtask

	task automatic t_wdOff();
		u_host.frame(`CMD_WR_CTRL, 16'h1000, 24, word);
		cyc(700);
		check("watchdog off", faultAlert, 1'b0);
	endtask

	task automatic t_loop();
		loopLowIn <= 1'b1;
		cyc(8);
		check("loop alert off", faultAlert, 1'b0);
		u_host.frame(`CMD_NOP, 16'h0000, 24, word);
		check("low loop flag", word, 16'h0200);
		u_host.frame(`CMD_WR_CTRL, 16'h1820, 24, word);
		cyc(2);
		check("loop alert on", faultAlert, 1'b1);
		u_host.frame(`CMD_RD_FAULT, 16'h0000, 24, word);
		check("no auto fault word", word, 16'h0000);
		u_host.frame(`CMD_NOP, 16'h0000, 24, word);
		check("fault readback", word, 16'h0200);
		loopLowIn <= 1'b0;
		cyc(8);
		check("loop alert gone", faultAlert, 1'b0);
	endtask

	initial begin
		t_reset();
		t_write();
		t_timeout();
		t_restart();
		t_wdOff();
		t_loop();
		finalReport();
	end

	// whole run is about 33000 cycles
	initial begin
		repeat (60000) @(posedge ref_clk);
		errCount++;
		finalReport();
	end
endmodule
